//--- core/bpp_pkg.sv
// package: register map, field positions and reset values of the port
package bpp_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] BPP_OFF_PIN_DATA   = 8'h06; // port_pin_data
  localparam logic [7:0] BPP_OFF_OPTION     = 8'h81; // option_control
  localparam logic [7:0] BPP_OFF_DIRECTION  = 8'h86; // port_direction
  localparam logic [7:0] BPP_OFF_INT_CTRL   = 8'h0B; // interrupt_control
  localparam logic [7:0] BPP_OFF_INT_MASK   = 8'h8B; // interrupt mask
  localparam logic [7:0] BPP_OFF_SYS_CTRL   = 8'h8C; // lvp / sleep control

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BPP_BIT_PULLUP_N  = 7; // pullup_enable_n in option
  localparam int BPP_BIT_EXT_EDGE  = 6; // ext_edge_select in option
  localparam int BPP_BIT_CHANGE    = 0; // port_change_flag
  localparam int BPP_BIT_EXT_INT   = 1; // external edge flag
  localparam int BPP_BIT_LVP       = 0; // low_voltage_programming
  localparam int BPP_BIT_SLEEP     = 1; // sleep request
  localparam int BPP_PIN_LVP       = 3; // third_port_pin
  localparam int BPP_PIN_EXT       = 0; // ext_interrupt_pin
  localparam int BPP_WATCH_LO      = 4; // lowest change_watch_pins bit

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] BPP_RST_OPTION    = 8'hFF;
  localparam logic [7:0] BPP_RST_DIRECTION = 8'hFF;
  localparam logic [7:0] BPP_RST_LATCH     = 8'h00;
  localparam logic [7:0] BPP_RST_SYS_CTRL  = 8'h01; // lvp on, awake
  localparam logic [1:0] BPP_RST_FLAGS     = 2'h0;

endpackage : bpp_pkg

//--- core/bpp_port.sv
// module: 8-bit bidirectional port with pull-ups and change interrupt
`timescale 1ns/10ps

module bpp_port
  import bpp_pkg::*;
#(
  parameter int WIDTH = 8 // pins in the port
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_srst,
  // register port
  input  wire logic [7:0]       i_addr,
  input  wire logic [7:0]       i_wdata,
  input  wire logic             i_wr,
  input  wire logic             i_rd,
  output logic      [7:0]       o_rdata,
  // pins
  input  wire logic [WIDTH-1:0] i_pin,
  output logic      [WIDTH-1:0] o_pin,
  output logic      [WIDTH-1:0] o_pin_oe,
  output logic      [WIDTH-1:0] o_pullup_en,
  // peripheral direction override
  input  wire logic [WIDTH-1:0] i_periph_en,
  input  wire logic [WIDTH-1:0] i_periph_out,
  input  wire logic [WIDTH-1:0] i_periph_dir_in,
  // interrupt and power
  output logic                  o_irq,
  output logic                  o_wake,
  output logic                  o_sleep,
  output logic                  o_lvp_pgm
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] sync1_q;          // first synchroniser stage
  logic [WIDTH-1:0] pin_q;            // synchronised pin levels
  logic [WIDTH-1:0] latch_q, latch_d; // output latch
  logic [WIDTH-1:0] dir_q, dir_d;     // direction, 1 = input
  logic [7:0]       opt_q, opt_d;     // option_control
  logic [1:0]       flag_q, flag_d;   // sticky flags
  logic [1:0]       mask_q, mask_d;   // interrupt enables
  logic [1:0]       sys_q, sys_d;     // lvp and sleep
  logic [3:0]       ref_q, ref_d;     // change reference copy
  logic             ext_prev_q;       // last pin 0 level
  logic [2:0]       warm_q, warm_d;   // edge detector warm-up shift
  logic [7:0]       rdata_d;
  logic [WIDTH-1:0] oe_d, out_d, pu_d, eff_in;
  logic [3:0]       watch_in, mismatch;
  logic             change_ev, ext_ev, acc_data;

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  // two flops before any logic reads the pins
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      sync1_q <= '0;
      pin_q   <= '0;
    end else begin
      sync1_q <= i_pin;
      pin_q   <= sync1_q;
    end
  end

  // ----------------------------------------------------------------
  // per-pin drive
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_pin
      always_comb begin
        if (g == BPP_PIN_LVP && sys_q[BPP_BIT_LVP]) begin
          // pin taken by programming logic: an input only
          eff_in[g] = 1'b1;
          out_d[g]  = 1'b0;
        end else if (i_periph_en[g]) begin
          // peripheral forces direction while enabled
          eff_in[g] = i_periph_dir_in[g];
          out_d[g]  = i_periph_out[g];
        end else begin
          eff_in[g] = dir_q[g];
          out_d[g]  = latch_q[g];
        end
        oe_d[g] = ~eff_in[g];
        // pull-up only on inputs with the active-low enable clear
        pu_d[g] = eff_in[g] & ~opt_q[BPP_BIT_PULLUP_N];
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // change and edge detection
  // ----------------------------------------------------------------
  always_comb begin
    acc_data  = (i_rd | i_wr) && i_addr == BPP_OFF_PIN_DATA;
    watch_in  = pin_q[WIDTH-1:BPP_WATCH_LO];
    // outputs drop out of the comparison
    mismatch  = (watch_in ^ ref_q) & eff_in[WIDTH-1:BPP_WATCH_LO];
    change_ev = |mismatch;
    // refresh the reference on any data access, ending a mismatch
    ref_d     = acc_data ? watch_in : ref_q;
    // both detector flops start at zero, so the first genuine pin
    // level after reset would pass for a rising edge on pin 0; edges
    // count only once the synchroniser and last-level flop are full
    warm_d    = {warm_q[1:0], 1'b1};
    ext_ev    = warm_q[2] & (opt_q[BPP_BIT_EXT_EDGE]
              ? (pin_q[BPP_PIN_EXT] & ~ext_prev_q)
              : (~pin_q[BPP_PIN_EXT] & ext_prev_q));
  end

  // ----------------------------------------------------------------
  // register writes and flags
  // ----------------------------------------------------------------
  always_comb begin
    latch_d = latch_q;
    dir_d   = dir_q;
    opt_d   = opt_q;
    mask_d  = mask_q;
    sys_d   = sys_q;
    flag_d  = flag_q;
    if (i_wr) begin
      case (i_addr)
        BPP_OFF_PIN_DATA:  latch_d = i_wdata[WIDTH-1:0];
        BPP_OFF_DIRECTION: dir_d   = i_wdata[WIDTH-1:0];
        BPP_OFF_OPTION:    opt_d   = i_wdata;
        BPP_OFF_INT_MASK:  mask_d  = i_wdata[1:0];
        BPP_OFF_SYS_CTRL:  sys_d   = i_wdata[1:0];
        // writing zero clears a flag
        BPP_OFF_INT_CTRL:  flag_d  = flag_q & i_wdata[1:0];
        default:           flag_d  = flag_q;
      endcase
    end
    // hardware set wins over a software clear in the same cycle
    if (change_ev) begin
      flag_d[BPP_BIT_CHANGE] = 1'b1;
    end
    if (ext_ev) begin
      flag_d[BPP_BIT_EXT_INT] = 1'b1;
    end
    // a change event ends sleep
    if (change_ev) begin
      sys_d[BPP_BIT_SLEEP] = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always_comb begin
    rdata_d = 8'h00;
    if (i_rd) begin
      case (i_addr)
        BPP_OFF_PIN_DATA:  rdata_d = 8'(pin_q);
        BPP_OFF_DIRECTION: rdata_d = 8'(dir_q);
        BPP_OFF_OPTION:    rdata_d = opt_q;
        BPP_OFF_INT_CTRL:  rdata_d = {6'h00, flag_q};
        BPP_OFF_INT_MASK:  rdata_d = {6'h00, mask_q};
        BPP_OFF_SYS_CTRL:  rdata_d = {6'h00, sys_q};
        default:           rdata_d = 8'h00; // unmapped reads zero
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      latch_q     <= WIDTH'(BPP_RST_LATCH);
      dir_q       <= WIDTH'(BPP_RST_DIRECTION);
      opt_q       <= BPP_RST_OPTION;
      mask_q      <= BPP_RST_FLAGS;
      flag_q      <= BPP_RST_FLAGS;
      sys_q       <= BPP_RST_SYS_CTRL[1:0];
      ref_q       <= '0;
      ext_prev_q  <= 1'b0;
      warm_q      <= '0;
      o_rdata     <= 8'h00;
      o_pin       <= '0;
      o_pin_oe    <= '0;
      o_pullup_en <= '0;
      o_irq       <= 1'b0;
      o_wake      <= 1'b0;
      o_sleep     <= 1'b0;
      o_lvp_pgm   <= BPP_RST_SYS_CTRL[BPP_BIT_LVP];
    end else begin
      latch_q     <= latch_d;
      dir_q       <= dir_d;
      opt_q       <= opt_d;
      mask_q      <= mask_d;
      flag_q      <= flag_d;
      sys_q       <= sys_d;
      ref_q       <= ref_d;
      ext_prev_q  <= pin_q[BPP_PIN_EXT];
      warm_q      <= warm_d;
      o_rdata     <= rdata_d;
      o_pin       <= out_d;
      o_pin_oe    <= oe_d;
      o_pullup_en <= pu_d;
      o_irq       <= |(flag_d & mask_d);
      o_wake      <= change_ev;
      o_sleep     <= sys_d[BPP_BIT_SLEEP];
      o_lvp_pgm   <= sys_d[BPP_BIT_LVP];
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  chk_pullup_output_off: assert property (
    ##1 (o_pin_oe & o_pullup_en) == '0)
    else $error("pull-up on while pin drives");

  chk_pullup_control: assert property (
    opt_q[BPP_BIT_PULLUP_N] |=> o_pullup_en == '0)
    else $error("pull-up on while disabled");

  chk_change_flag_set: assert property (
    change_ev |=> flag_q[BPP_BIT_CHANGE])
    else $error("change flag not set");

  // a clear written while the mismatch lives does not hold
  chk_mismatch_persist: assert property (
    change_ev && i_wr && i_addr == BPP_OFF_INT_CTRL
    |=> flag_q[BPP_BIT_CHANGE])
    else $error("change flag cleared during mismatch");

  chk_ref_refresh: assert property (
    acc_data && !i_srst |=> ref_q == $past(watch_in))
    else $error("reference not refreshed");

  chk_flag_sticky: assert property (
    flag_q[BPP_BIT_CHANGE] && !(i_wr && i_addr == BPP_OFF_INT_CTRL)
    |=> flag_q[BPP_BIT_CHANGE])
    else $error("change flag dropped");

  chk_output_drive: assert property (
    !dir_q[1] && !i_periph_en[1]
    |=> o_pin_oe[1] && o_pin[1] == $past(latch_q[1]))
    else $error("output pin not driven by latch");

  chk_lvp_pin_in: assert property (
    sys_q[BPP_BIT_LVP] |=> !o_pin_oe[BPP_PIN_LVP])
    else $error("lvp pin driven");

  chk_wake_event: assert property (
    change_ev |=> o_wake && !sys_q[BPP_BIT_SLEEP])
    else $error("no wake on change");

  chk_ext_edge: assert property (
    ext_ev |=> flag_q[BPP_BIT_EXT_INT])
    else $error("edge flag not set");

  // pull-up turns on for an input pin once the enable bit is clear
  chk_pullup_on: assert property (
    !opt_q[BPP_BIT_PULLUP_N] && dir_q[5] && !i_periph_en[5]
    |=> o_pullup_en[5])
    else $error("pull-up off on enabled input");

  // a software clear holds only while no mismatch is live
  chk_flag_clear: assert property (
    i_wr && i_addr == BPP_OFF_INT_CTRL && !i_wdata[BPP_BIT_CHANGE]
    && !change_ev |=> !flag_q[BPP_BIT_CHANGE])
    else $error("change flag survived a clear");

  // interrupt line follows the enabled flags with no extra delay
  chk_irq_level: assert property (
    o_irq == |(flag_q & mask_q))
    else $error("interrupt line disagrees with flags");

  // the reference copy moves only on a data register access
  chk_ref_hold: assert property (
    !acc_data |=> ref_q == $past(ref_q))
    else $error("reference changed without access");

  // read data stand for one cycle and read zero otherwise
  chk_rdata_idle: assert property (
    !i_rd |=> o_rdata == 8'h00)
    else $error("read data without a read");

  // rising edge on pin 0 with rising selected raises the edge flag
  chk_ext_rise: assert property (
    warm_q[2] && opt_q[BPP_BIT_EXT_EDGE] && $rose(pin_q[BPP_PIN_EXT])
    |=> flag_q[BPP_BIT_EXT_INT])
    else $error("rising edge missed");

  // falling edge on pin 0 with falling selected raises the edge flag
  chk_ext_fall: assert property (
    warm_q[2] && !opt_q[BPP_BIT_EXT_EDGE] && $fell(pin_q[BPP_PIN_EXT])
    |=> flag_q[BPP_BIT_EXT_INT])
    else $error("falling edge missed");

  // a peripheral that takes pin 0 as output drives its own value
  chk_periph_drive: assert property (
    i_periph_en[0] && !i_periph_dir_in[0]
    |=> o_pin_oe[0] && o_pin[0] == $past(i_periph_out[0]))
    else $error("peripheral output not driven");

  // a peripheral that takes pin 0 as input releases the driver
  chk_periph_input: assert property (
    i_periph_en[0] && i_periph_dir_in[0] |=> !o_pin_oe[0])
    else $error("peripheral input pin driven");

  // once programming lets go, pin 3 follows its direction bit
  chk_lvp_release: assert property (
    !sys_q[BPP_BIT_LVP] && !dir_q[BPP_PIN_LVP] && !i_periph_en[BPP_PIN_LVP]
    |=> o_pin_oe[BPP_PIN_LVP])
    else $error("pin 3 not released for general use");

  // ----------------------------------------------------------------
  // coverage of the main scenarios
  // ----------------------------------------------------------------
  // change event reaching the interrupt line
  cov_change_irq: cover property (change_ev ##1 o_irq);
  // data register access (read or write) ending a live mismatch
  cov_data_read_clear: cover property (change_ev ##1 acc_data ##1 !change_ev);
  // peripheral taking over a pin
  cov_periph_override: cover property (i_periph_en != '0);
  // pin 0 edge reaching the interrupt line
  cov_ext_irq: cover property (ext_ev ##1 o_irq);

endmodule : bpp_port

//--- testbench/bpp_key_model.sv
// partner model: keys and board wiring on the eight port pins
`timescale 1ns/10ps

module bpp_key_model (
  // clock
  input  wire logic       i_clk,
  // port side
  input  wire logic [7:0] i_drv,
  input  wire logic [7:0] i_drv_oe,
  input  wire logic [7:0] i_pullup_en,
  // key side
  input  wire logic [7:0] i_key_en,
  input  wire logic [7:0] i_key_val,
  // resolved pin level
  output logic      [7:0] o_level
);
  logic [7:0] last_q = 8'h00; // last level, so a floating pin drifts

  // ----------------------------------------------------------------
  // pin resolution
  // ----------------------------------------------------------------
  // driver wins, then a key, then the weak pull-up; a floating pin
  // shows the inverse of its last level so no stale value survives
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (i_drv_oe[i])
        o_level[i] = i_drv[i];
      else if (i_key_en[i])
        o_level[i] = i_key_val[i];
      else if (i_pullup_en[i])
        o_level[i] = 1'b1;
      else
        o_level[i] = ~last_q[i];
    end
  end

  // remember the last level that something gave each pin; a pin left
  // open keeps showing the inverse of that level instead of toggling
  always_ff @(posedge i_clk) begin
    for (int i = 0; i < 8; i++) begin
      if (i_drv_oe[i] | i_key_en[i] | i_pullup_en[i]) begin
        last_q[i] <= o_level[i];
      end
    end
  end
endmodule : bpp_key_model

//--- testbench/tb_bpp_port.sv
// testbench: random and corner cases for the bidirectional port
`timescale 1ns/10ps

module tb_bpp_port;
  import bpp_pkg::*;
  logic        i_clk = 1'b0, i_srst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
  logic [7:0]  i_addr = 8'h00, i_wdata = 8'h00;
  logic [7:0]  pe = 8'h00, po = 8'h00, pdi = 8'h00; // peripheral override
  logic [7:0]  key_en = 8'hFF, key_val = 8'hFF;     // keys on the pins
  logic [7:0]  o_rdata, o_pin, o_pin_oe, o_pullup_en, pin, rdv;
  logic        o_irq, o_wake, o_sleep, o_lvp_pgm;
  logic [31:0] seed = 32'h4A18;                     // lfsr state
  // after reset the change flag is up (zero reference), the edge flag not
  logic [7:0]  ra [6] = '{8'h81, 8'h86, 8'h8C, 8'h8B, 8'h10, 8'h0B};
  logic [7:0]  rv [6] = '{8'hFF, 8'hFF, 8'h01, 8'h00, 8'h00, 8'h01};
  int          n_mismatch = 0, compares = 0, cyc = 0;

  bpp_port dut (.i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_pin(pin), .o_pin(o_pin), .o_pin_oe(o_pin_oe),
    .o_pullup_en(o_pullup_en), .i_periph_en(pe), .i_periph_out(po),
    .i_periph_dir_in(pdi), .o_irq(o_irq), .o_wake(o_wake),
    .o_sleep(o_sleep), .o_lvp_pgm(o_lvp_pgm));
  bpp_key_model keys (.i_clk(i_clk), .i_drv(o_pin), .i_drv_oe(o_pin_oe),
    .i_pullup_en(o_pullup_en), .i_key_en(key_en), .i_key_val(key_val),
    .o_level(pin));

  // ----------------------------------------------------------------
  // clock, timeout and helpers
  // ----------------------------------------------------------------
  always #2.5 i_clk = ~i_clk;

  // cut a hang short
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  // next random word
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr

  // one-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 rdv = o_rdata;
  endtask : rd

  task automatic st;
    repeat (6) @(posedge i_clk);
    #1;
  endtask : st

  task automatic key(input logic [7:0] v);
    @(posedge i_clk);
    key_val <= v;
  endtask : key

  // bounded wait for the interrupt line
  task automatic wirq;
    int k;
    k = 0;
    while (o_irq !== 1'b1 && k < 20) begin
      @(posedge i_clk);
      k++;
    end
    #1;
  endtask : wirq

  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge i_clk);
    i_srst <= 1'b0;
    st;
    chk(o_pullup_en, 8'h00);
    chk({7'h00, o_lvp_pgm}, 8'h01);
    foreach (ra[i]) begin
      rd(ra[i]);
      chk(rdv, rv[i]);
    end
    // whole-byte direction writes only, never read-modify-write
    wr(BPP_OFF_DIRECTION, 8'h00);
    st;
    chk(o_pin_oe, 8'hF7);
    wr(BPP_OFF_SYS_CTRL, 8'h00);
    st;
    chk(o_pin_oe, 8'hFF);
    chk({7'h00, o_lvp_pgm}, 8'h00);
    for (int n = 0; n < 8; n++) begin
      seed = lfsr(seed);
      wr(BPP_OFF_PIN_DATA, seed[7:0]);
      st;
      chk(o_pin, seed[7:0]);
      rd(BPP_OFF_PIN_DATA);
      chk(rdv, seed[7:0]);
    end
    wr(BPP_OFF_DIRECTION, 8'hF0);
    wr(BPP_OFF_OPTION, 8'h7F);
    st;
    chk(o_pullup_en, 8'hF0);
    // keys let go of the upper pins: only the pull-ups hold them high
    @(posedge i_clk);
    key_en <= 8'h0F;
    st;
    rd(BPP_OFF_PIN_DATA);
    chk(rdv, {4'hF, seed[3:0]});
    wr(BPP_OFF_OPTION, 8'hFF);
    st;
    chk(o_pullup_en, 8'h00);
    // with the pull-ups off the open pins drift away from high
    rd(BPP_OFF_PIN_DATA);
    chk(rdv, {4'h0, seed[3:0]});
    @(posedge i_clk);
    key_en <= 8'hFF;
    // change watch: no polling of the data register meanwhile
    wr(BPP_OFF_DIRECTION, 8'hFF);
    wr(BPP_OFF_INT_MASK, 8'h00);
    rd(BPP_OFF_PIN_DATA);
    // sleep is requested only once no mismatch is live to cancel it
    wr(BPP_OFF_SYS_CTRL, 8'h02);
    wr(BPP_OFF_INT_CTRL, 8'h00);
    key(8'hFB);
    st;
    rd(BPP_OFF_INT_CTRL);
    chk(rdv & 8'h01, 8'h00);
    chk({7'h00, o_sleep}, 8'h01);
    key(8'h7B);
    st;
    chk({7'h00, o_irq}, 8'h00);
    chk({6'h00, o_wake, o_sleep}, 8'h02);
    rd(BPP_OFF_INT_CTRL);
    chk(rdv & 8'h01, 8'h01);
    wr(BPP_OFF_INT_CTRL, 8'h00);
    rd(BPP_OFF_INT_CTRL);
    chk(rdv & 8'h01, 8'h01);
    wr(BPP_OFF_INT_MASK, 8'h01);
    wirq;
    chk({7'h00, o_irq}, 8'h01);
    wr(BPP_OFF_PIN_DATA, 8'h00);
    wr(BPP_OFF_INT_CTRL, 8'h00);
    st;
    chk({7'h00, o_irq}, 8'h00);
    wr(BPP_OFF_INT_MASK, 8'h02);
    for (int e = 1; e >= 0; e--) begin
      wr(BPP_OFF_OPTION, e[0] ? 8'hFF : 8'hBF);
      key({key_val[7:1], ~e[0]});
      st;
      wr(BPP_OFF_INT_CTRL, 8'h00);
      st;
      chk({7'h00, o_irq}, 8'h00);
      key({key_val[7:1], e[0]});
      wirq;
      chk({7'h00, o_irq}, 8'h01);
    end
    @(posedge i_clk);
    pe <= 8'h01;
    po <= 8'h01;
    st;
    chk(o_pin_oe & o_pin & 8'h01, 8'h01);
    @(posedge i_clk);
    pdi <= 8'h01;
    wr(BPP_OFF_DIRECTION, 8'h00);
    st;
    chk(o_pin_oe, 8'hFE);
    give_verdict();
  end
endmodule : tb_bpp_port
